/* rtl/etp_trig_b.sv */
`timescale 1ns/1ps
`default_nettype none
`include "etp_consts.svh"
module etp_trig_b
   import etp_pkg::*;
(
   // Clock and reset.
   input  wire logic         sys_clk,
   input  wire logic         reset,
   // Avalon-MM slave.
   input  wire logic [2:0]   avs_address,
   input  wire logic         avs_read,
   input  wire logic         avs_write,
   input  wire logic [31:0]  avs_writedata,
   output logic [31:0]       avs_readdata,
   output logic              avs_waitrequest,
   // Time-base events, same clock.
   input  wire etp_events_s  tb_events,
   // Outputs.
   output logic              adc_start_pulse_b,
   output logic              irq
);
   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   logic [15:0] event_trigger_select;
   logic [1:0]  trig_b_threshold;
   logic [1:0]  trig_b_event_tally;
   logic [1:0]  trig_a_threshold;
   logic [1:0]  irq_threshold;
   logic        event_trigger_flags;
   logic        irq_mask;
   logic        rd_done;

   // --------------------------------------------------------------
   // Decode
   // --------------------------------------------------------------
   // Reads take one wait cycle so that read data come from a flop.
   wire rd_sel    = avs_read & ~rd_done;
   wire wr_select = avs_write & (avs_address == `ETP_ADDR_SELECT);
   wire wr_presc  = avs_write & (avs_address == `ETP_ADDR_PRESCALE);
   wire wr_mask   = avs_write & (avs_address == `ETP_ADDR_IRQ_MASK);
   wire rd_flags  = avs_read & rd_done & (avs_address == `ETP_ADDR_FLAGS);
   assign avs_waitrequest = rd_sel;

   wire [2:0] trig_b_event_select =
      event_trigger_select[`ETP_B_SEL_HI:`ETP_B_SEL_LO];
   wire trig_b_enable = event_trigger_select[`ETP_B_EN_BIT];

   // --------------------------------------------------------------
   // Event selection
   // --------------------------------------------------------------
   logic sel_event;
   always_comb begin
      case (trig_b_event_select)
         `ETP_SEL_ZERO:   sel_event = tb_events.ctr_zero;
         `ETP_SEL_PERIOD: sel_event = tb_events.ctr_period;
         `ETP_SEL_CA_UP:  sel_event = tb_events.cmpa_up;
         `ETP_SEL_CA_DN:  sel_event = tb_events.cmpa_down;
         `ETP_SEL_CB_UP:  sel_event = tb_events.cmpb_up;
         `ETP_SEL_CB_DN:  sel_event = tb_events.cmpb_down;
         default:         sel_event = 1'b0;
      endcase
   end

   // --------------------------------------------------------------
   // Prescaler
   // --------------------------------------------------------------
   // The tally stops at the threshold; reaching it while disabled holds
   // it there rather than wrapping, so no event count is lost.
   wire counting   = (trig_b_threshold != `ETP_THR_OFF);
   wire [1:0] inc  = trig_b_event_tally + `ETP_TALLY_ONE;
   wire at_thr     = (trig_b_event_tally >= trig_b_threshold);
   wire next_hit   = counting & sel_event & (at_thr | inc == trig_b_threshold);
   // Status flag plays no part here.
   wire fire       = next_hit & trig_b_enable;
   logic [1:0] next_tally;
   always_comb begin
      if (!counting)
         next_tally = `ETP_TALLY_ZERO;
      else if (fire)
         next_tally = `ETP_TALLY_ZERO;
      else if (sel_event & ~at_thr)
         next_tally = inc;
      else
         next_tally = trig_b_event_tally;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         trig_b_event_tally <= `ETP_TALLY_ZERO;
         adc_start_pulse_b  <= 1'b0;
      end else begin
         trig_b_event_tally <= next_tally;
         adc_start_pulse_b  <= fire;
      end
   end

   // --------------------------------------------------------------
   // Register writes
   // --------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         event_trigger_select <= `ETP_RESET_16;
         trig_b_threshold     <= `ETP_THR_OFF;
         trig_a_threshold     <= `ETP_THR_OFF;
         irq_threshold        <= `ETP_THR_OFF;
         irq_mask             <= 1'b0;
         rd_done              <= 1'b0;
      end else begin
         rd_done <= rd_sel;
         if (wr_select)
            event_trigger_select <= avs_writedata[15:0] & `ETP_SELECT_MASK;
         if (wr_presc) begin
            trig_b_threshold <= avs_writedata[`ETP_B_THR_HI:`ETP_B_THR_LO];
            trig_a_threshold <=
               avs_writedata[`ETP_A_THR_HI:`ETP_A_THR_LO];
            irq_threshold    <=
               avs_writedata[`ETP_INT_THR_HI:`ETP_INT_THR_LO];
         end
         if (wr_mask)
            irq_mask <= avs_writedata[0];
      end
   end

   // Sticky status: set wins over the read that clears it.
   // The read data are captured one edge before the clear, so only a flag
   // that software has actually seen is cleared; a pulse that lands in
   // the wait cycle stays pending for the next read.
   wire flag_seen = avs_readdata[`ETP_FLAG_BIT];
   always_ff @(posedge sys_clk) begin
      if (reset)
         event_trigger_flags <= 1'b0;
      else if (fire)
         event_trigger_flags <= 1'b1;
      else if (rd_flags & flag_seen)
         event_trigger_flags <= 1'b0;
   end
   assign irq = event_trigger_flags & irq_mask;

   // --------------------------------------------------------------
   // Read data
   // --------------------------------------------------------------
   // Other tallies are not implemented here and read as zero.
   wire [15:0] presc_word = {trig_b_event_tally, trig_b_threshold,
                             2'h0, trig_a_threshold, 4'h0, 2'h0,
                             irq_threshold};
   logic [15:0] rd_word;
   always_comb begin
      case (avs_address)
         `ETP_ADDR_SELECT:   rd_word = event_trigger_select;
         `ETP_ADDR_PRESCALE: rd_word = presc_word;
         `ETP_ADDR_FLAGS:    rd_word = {15'h0000, event_trigger_flags};
         `ETP_ADDR_IRQ_MASK: rd_word = {15'h0000, irq_mask};
         default:            rd_word = `ETP_RESET_16;
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (reset)
         avs_readdata <= 32'h0000_0000;
      else if (rd_sel)
         avs_readdata <= {16'h0000, rd_word};
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   sequence hit_s;
      next_hit && trig_b_enable;
   endsequence
   sequence read_req_s;
      avs_read && !rd_done;
   endsequence
   sequence read_done_s;
      !avs_waitrequest && rd_done;
   endsequence
   sequence presc_read_s;
      avs_read && !rd_done && (avs_address == `ETP_ADDR_PRESCALE);
   endsequence
   read_wait_a: assert property (@(posedge sys_clk) disable iff (reset)
      read_req_s |-> avs_waitrequest)
      else $error("Read not held for its wait cycle.");
   read_answer_a: assert property (@(posedge sys_clk) disable iff (reset)
      read_req_s |=> read_done_s)
      else $error("Read not answered after one wait cycle.");
   write_nowait_a: assert property (@(posedge sys_clk) disable iff (reset)
      avs_write |-> !avs_waitrequest)
      else $error("Write was stalled.");
   flag_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      hit_s |=> event_trigger_flags)
      else $error("Status flag not set by a pulse.");
   tally_inc_a: assert property (@(posedge sys_clk) disable iff (reset)
      (counting && sel_event && !next_hit
         && trig_b_event_tally < trig_b_threshold)
         |=> trig_b_event_tally == 2'($past(trig_b_event_tally) + 2'h1))
      else $error("Tally did not step on an event.");
   pulse_on_hit_a: assert property (@(posedge sys_clk) disable iff (reset)
      hit_s |=> adc_start_pulse_b)
      else $error("Trigger B pulse missing.");
   no_pulse_off_a: assert property (@(posedge sys_clk) disable iff (reset)
      (trig_b_threshold == `ETP_THR_OFF) |=> !adc_start_pulse_b
         && trig_b_event_tally == `ETP_TALLY_ZERO)
      else $error("Pulse or tally while disabled.");
   enable_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
      !trig_b_enable |=> !adc_start_pulse_b)
      else $error("Pulse while not enabled.");
   flag_no_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      (event_trigger_flags and hit_s) |=> adc_start_pulse_b)
      else $error("Flag blocked a pulse.");
   tally_clear_a: assert property (@(posedge sys_clk) disable iff (reset)
      adc_start_pulse_b |-> trig_b_event_tally == `ETP_TALLY_ZERO)
      else $error("Tally not cleared.");
   tally_bound_a: assert property (@(posedge sys_clk) disable iff (reset)
      // A threshold lowered below the tally leaves the tally parked above
      // it until the next event fires, so only in-range tallies are bound.
      (counting && trig_b_event_tally <= trig_b_threshold)
         |=> trig_b_event_tally <= $past(trig_b_threshold))
      else $error("Tally passed threshold.");
   tally_step_a: assert property (@(posedge sys_clk) disable iff (reset)
      (counting && !sel_event && $stable(trig_b_threshold))
         |=> $stable(trig_b_event_tally))
      else $error("Tally moved without event.");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
      presc_read_s |=> avs_readdata[7:4] == 4'h0
         && avs_readdata[15:0] == $past(presc_word))
      else $error("Reserved bits not zero.");
endmodule // etp_trig_b
`default_nettype wire

/* rtl/etp_consts.svh */
// Summary of operation
// - Read-only two-bit trigger-B tally sits in prescale bits 15 to 14.
// - Read/write two-bit trigger-B threshold sits in prescale bits 13 to 12.
// - Threshold 00 disables the tally and never emits a trigger-B pulse.
// - Thresholds 01, 10, 11 emit on the first, second, third event.
// - A pulse is emitted only while the trigger-B enable bit is one.
// - A pending trigger-B status flag never blocks a new pulse.
// - Emitting a trigger-B pulse clears the tally to zero.
// - Other tallies read-only, thresholds read/write, bits 7-4 zero, reset zero.
// - Event select codes pick zero, period, compare A/B up or down.
// - Enable bit 15 of the select register gates the trigger-B pulse.
`ifndef ETP_CONSTS_SVH
`define ETP_CONSTS_SVH
`define ETP_ADDR_SELECT    3'h0
`define ETP_ADDR_PRESCALE  3'h1
`define ETP_ADDR_FLAGS     3'h2
`define ETP_ADDR_IRQ_MASK  3'h3
`define ETP_B_EN_BIT       15
`define ETP_B_SEL_HI       14
`define ETP_B_SEL_LO       12
`define ETP_A_EN_BIT       11
`define ETP_A_SEL_HI       10
`define ETP_A_SEL_LO       8
`define ETP_INT_EN_BIT     3
`define ETP_INT_SEL_HI     2
`define ETP_INT_SEL_LO     0
`define ETP_SELECT_MASK    16'hFF0F
`define ETP_PRESCALE_MASK  16'h3303
`define ETP_B_THR_HI       13
`define ETP_B_THR_LO       12
`define ETP_A_THR_HI       9
`define ETP_A_THR_LO       8
`define ETP_INT_THR_HI     1
`define ETP_INT_THR_LO     0
`define ETP_FLAG_BIT       0
`define ETP_SEL_ZERO       3'h1
`define ETP_SEL_PERIOD     3'h2
`define ETP_SEL_CA_UP      3'h4
`define ETP_SEL_CA_DN      3'h5
`define ETP_SEL_CB_UP      3'h6
`define ETP_SEL_CB_DN      3'h7
`define ETP_THR_OFF        2'h0
`define ETP_TALLY_ONE      2'h1
`define ETP_TALLY_ZERO     2'h0
`define ETP_RESET_16       16'h0000
`endif

/* rtl/etp_pkg.sv */
package etp_pkg;
   typedef struct packed {
      logic ctr_zero;
      logic ctr_period;
      logic cmpa_up;
      logic cmpa_down;
      logic cmpb_up;
      logic cmpb_down;
   } etp_events_s;
endpackage

/* verification/etp_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Converter start input seen from the far side.
// ----------------------------------------
// It only tallies starts, since a real converter accepts one on any cycle.
module etp_adc_model (
   // Clock and reset.
   input  wire logic sys_clk,
   input  wire logic reset,
   // Start request from the prescaler.
   input  wire logic start_b,
   output var  int   n_starts
);
   always_ff @(posedge sys_clk) begin
      if (reset) n_starts <= 0;
      else if (start_b === 1'b1) n_starts <= n_starts + 1;
   end
endmodule // etp_adc_model
`default_nettype wire

/* verification/adc_trigger_b_prescaler_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_b_prescaler_test
   import etp_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  adr = 3'h0;
   logic        rd_en = 1'b0;
   logic        wr_en = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        wait_req;
   etp_events_s ev = '0;
   logic        pulse;
   logic        irq;
   logic [31:0] v;
   int          starts;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cycles = 0;
   int          n_exp = 0;

   always #4 sys_clk = ~sys_clk;

   etp_trig_b dut_u (.sys_clk(sys_clk), .reset(reset), .avs_address(adr),
      .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat),
      .avs_readdata(rdat), .avs_waitrequest(wait_req), .tb_events(ev),
      .adc_start_pulse_b(pulse), .irq(irq));
   etp_adc_model adc_u (.sys_clk(sys_clk), .reset(reset), .start_b(pulse),
      .n_starts(starts));

   // ----------------------------------------
   // Shared tasks.
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // A read holds until waitrequest is seen low, so no latency is assumed.
   task automatic bus(input logic [2:0] a, input logic wr,
                      input logic [15:0] d);
      @(posedge sys_clk);
      adr <= a;
      wdat <= {16'h0000, d};
      rd_en <= !wr;
      wr_en <= wr;
      #1;
      while (wait_req !== 1'b0) begin
         @(posedge sys_clk);
         #1;
      end
      v = rdat;
      @(posedge sys_clk);
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask

   task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
      bus(a, 1'b0, 16'h0000);
      chk(v, {16'h0000, exp});
   endtask

   task automatic fire(input int b, input logic exp_pulse);
      @(posedge sys_clk);
      ev <= 6'(1 << b);
      @(posedge sys_clk);
      ev <= '0;
      #1 chk(pulse, exp_pulse);
      n_exp += exp_pulse;
   endtask

   task automatic finish_test;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles > 20000) begin
         error_cnt++;
         finish_test;
      end
   end

   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial begin
      int b;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      rchk(3'h1, 16'h0000);
      rchk(3'h2, 16'h0000);
      bus(3'h1, 1'b1, 16'hFFFF);
      rchk(3'h1, 16'h3303);
      bus(3'h0, 1'b1, 16'hFFFF);
      rchk(3'h0, 16'hFF0F);
      rchk(3'h5, 16'h0000);
      bus(3'h3, 1'b1, 16'h0001);
      bus(3'h1, 1'b1, 16'h0000);
      bus(3'h0, 1'b1, 16'h9000);
      fire(5, 1'b0);
      fire(5, 1'b0);
      rchk(3'h1, 16'h0000);
      // Later pulses fire with the status flag still pending.
      for (int c = 1; c < 8; c++) if (c != 3) for (int t = 1; t < 4; t++) begin
         b = (c < 4) ? 6 - c : 7 - c;
         bus(3'h0, 1'b1, 16'(16'h8000 | (c << 12)));
         bus(3'h1, 1'b1, 16'(t << 12));
         fire((b + 1) % 6, 1'b0);
         for (int k = 1; k < t; k++) begin
            fire(b, 1'b0);
            rchk(3'h1, 16'((t << 12) | (k << 14)));
         end
         fire(b, 1'b1);
         rchk(3'h1, 16'(t << 12));
      end
      chk(irq, 1'b1);
      rchk(3'h2, 16'h0001);
      @(posedge sys_clk);
      #1 chk(irq, 1'b0);
      bus(3'h0, 1'b1, 16'h1000);
      bus(3'h1, 1'b1, 16'h1000);
      fire(5, 1'b0);
      bus(3'h0, 1'b1, 16'h9000);
      bus(3'h3, 1'b1, 16'h0000);
      fire(5, 1'b1);
      chk(irq, 1'b0);
      rchk(3'h2, 16'h0001);
      chk(32'(starts), 32'(n_exp));
      finish_test;
   end
endmodule // adc_trigger_b_prescaler_test
`default_nettype wire
